// ---- hdl/io_bus_handshake_timer.sv ----
// Behaviour
// - Start only on Load naming I/O as source (input) or destination (output).
// - Idle or reset: clock-stop flop set, control-line flop cleared.
// - About 40 ns after command clock falls, clear clock-stop, halting clocks.
// - No system clock pulses until clock-stop is set again.
// - Control line sets only with clock-stop cleared and sync inactive.
// - Output select 01 data-available, 10 address, 11 command strobe.
// - Input select 01 data-request, 10 acknowledge, 11 status-request.
// - Output operations drive result bits 8:15 onto output data lines.
// - Input operations pass input lines to operand bits 8:15 unless false sync.
// - False-sync flop armed only while control-line flop is set.
// - No sync within about 45 us gives a false sync.
// - A received sync resets the false-sync flop.
// - Clock-stop stays cleared until sync or false sync, then sets.
// - First resumed clock loads the input response into the destination.
// - Same resumed clock fetches next micro-instruction, clears control line.
// - Clearing the control-line flop drops the strobe.
// - Clearing the control-line flop disengages the false-sync flop.
// - Another I/O Load halts the clocks again for the new transfer.
// - A non-I/O next instruction returns the timer to initial state.
// - False sync ending any operation sets the overflow flag.
// - False sync on status request forces operand value 0004.
`timescale 1ns/1ps
`default_nettype none
module io_bus_handshake_timer #(
  parameter int FS_TIMEOUT_CYCLES = io_timer_pkg::FS_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // Processor micro-instruction side
  input wire logic [15:0] micro_word,
  input wire logic command_clock,
  input wire logic [7:0] result_bus,
  output logic sys_clock_run,
  output logic [15:0] operand_bus,
  output logic operand_load,
  output logic fetch_next,
  output logic overflow_flag,
  // I/O bus pins
  input wire logic device_sync,
  input wire logic [7:0] input_data_lines,
  output logic [7:0] output_data_lines,
  output io_timer_pkg::strobes_s strobes
);

  // Pin synchronisers
  logic sync_meta_reg;
  logic sync_reg;
  logic [7:0] din_meta_reg;
  logic [7:0] din_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      din_meta_reg <= 8'h00;
      din_reg <= 8'h00;
    end else if (clk_en) begin
      sync_meta_reg <= device_sync;
      sync_reg <= sync_meta_reg;
      din_meta_reg <= input_data_lines;
      din_reg <= din_meta_reg;
    end
  end

  // Instruction decode
  logic io_is_source;
  logic io_is_destination;
  logic load_op;
  logic io_op_qualified;
  logic ctrl_en_reg;

  assign load_op = micro_word[io_timer_pkg::OPC_MSB -: 4] ==
                   io_timer_pkg::OP_LOAD;
  assign io_is_source = micro_word[io_timer_pkg::SRC_MSB -: 4] ==
                        io_timer_pkg::FIELD_IO;
  assign io_is_destination = micro_word[io_timer_pkg::DST_MSB -: 4] ==
                             io_timer_pkg::FIELD_IO;
  assign io_op_qualified = ctrl_en_reg & load_op &
                           (io_is_source | io_is_destination);

  // Sequencer state
  io_timer_pkg::state_e state_reg, state_next;
  logic ccl_prev_reg, ccl_prev_next;
  logic [io_timer_pkg::DLY_W-1:0] dly_reg, dly_next;
  logic [io_timer_pkg::TMO_W-1:0] tmo_reg, tmo_next;
  logic clock_stop_ff, clock_stop_next;
  logic control_line_active_ff, ctl_next;
  logic gated_false_sync, gfs_next;
  logic false_sync_timeout;
  logic dir_in_reg, dir_in_next;
  logic [1:0] sel_reg, sel_next;
  logic [7:0] dal_reg, dal_next;
  io_timer_pkg::strobes_s strobes_reg, strobes_next;
  logic [15:0] operand_reg, operand_next;
  logic operand_load_reg, operand_load_next;
  logic fetch_reg, fetch_next_v;
  logic [7:0] last_byte_reg, last_byte_next;
  logic ovf_set;
  logic ccl_fall;

  assign ccl_fall = ccl_prev_reg & ~command_clock;
  assign false_sync_timeout = tmo_reg ==
         io_timer_pkg::TMO_W'(FS_TIMEOUT_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    ccl_prev_next = command_clock;
    dly_next = dly_reg;
    tmo_next = tmo_reg;
    clock_stop_next = clock_stop_ff;
    ctl_next = control_line_active_ff;
    gfs_next = gated_false_sync;
    dir_in_next = dir_in_reg;
    sel_next = sel_reg;
    dal_next = dal_reg;
    operand_next = operand_reg;
    operand_load_next = 1'b0;
    fetch_next_v = 1'b0;
    last_byte_next = last_byte_reg;
    ovf_set = 1'b0;
    case (state_reg)
      io_timer_pkg::ST_IDLE: begin
        clock_stop_next = 1'b1;
        ctl_next = 1'b0;
        gfs_next = 1'b0;
        dal_next = 8'h00;
        if (ccl_fall && io_op_qualified && !control_line_active_ff) begin
          state_next = io_timer_pkg::ST_DELAY;
          dly_next = '0;
          dir_in_next = io_is_source;
          sel_next = micro_word[io_timer_pkg::SEL_MSB -: 2];
          dal_next = io_is_source ? 8'h00 : result_bus;
        end
      end
      io_timer_pkg::ST_DELAY: begin
        dly_next = dly_reg + 1'b1;
        if (dly_reg == io_timer_pkg::DLY_W'(io_timer_pkg::CMD_DELAY_CYC - 1))
        begin
          clock_stop_next = 1'b0;
          state_next = io_timer_pkg::ST_HALT;
        end
      end
      io_timer_pkg::ST_HALT: begin
        if (!clock_stop_ff && !sync_reg) begin
          ctl_next = 1'b1;
          tmo_next = '0;
          state_next = io_timer_pkg::ST_WAIT;
        end
      end
      io_timer_pkg::ST_WAIT: begin
        tmo_next = tmo_reg + 1'b1;
        if (sync_reg) begin
          gfs_next = 1'b0;
          clock_stop_next = 1'b1;
          state_next = io_timer_pkg::ST_RESUME;
        end else if (false_sync_timeout && control_line_active_ff) begin
          gfs_next = 1'b1;
          clock_stop_next = 1'b1;
          state_next = io_timer_pkg::ST_RESUME;
        end
      end
      io_timer_pkg::ST_RESUME: begin
        fetch_next_v = 1'b1;
        ctl_next = 1'b0;
        gfs_next = 1'b0;
        ovf_set = gated_false_sync;
        state_next = io_timer_pkg::ST_IDLE;
        dal_next = 8'h00;
        if (dir_in_reg) begin
          operand_load_next = 1'b1;
          if (!gated_false_sync) begin
            operand_next = {8'h00, din_reg};
            last_byte_next = din_reg;
          end else if (sel_reg == io_timer_pkg::SEL_CMD_STAT) begin
            operand_next = io_timer_pkg::STATUS_FORCED;
          end else begin
            operand_next = 16'h0000;
          end
        end
      end
      default: begin
        state_next = io_timer_pkg::ST_IDLE;
        clock_stop_next = 1'b1;
        ctl_next = 1'b0;
        gfs_next = 1'b0;
      end
    endcase
    // Strobe follows the control-line flop
    strobes_next = '0;
    if (ctl_next) begin
      if (dir_in_next) begin
        strobes_next.data_request_strobe = sel_next ==
                                           io_timer_pkg::SEL_DATA;
        strobes_next.acknowledge_strobe = sel_next ==
                                          io_timer_pkg::SEL_ADDR_ACK;
        strobes_next.status_request_strobe = sel_next ==
                                             io_timer_pkg::SEL_CMD_STAT;
      end else begin
        strobes_next.data_available_strobe = sel_next ==
                                             io_timer_pkg::SEL_DATA;
        strobes_next.address_strobe = sel_next ==
                                      io_timer_pkg::SEL_ADDR_ACK;
        strobes_next.command_strobe = sel_next ==
                                      io_timer_pkg::SEL_CMD_STAT;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= io_timer_pkg::ST_IDLE;
      ccl_prev_reg <= 1'b0;
      dly_reg <= '0;
      tmo_reg <= '0;
      clock_stop_ff <= 1'b1;
      control_line_active_ff <= 1'b0;
      gated_false_sync <= 1'b0;
      dir_in_reg <= 1'b0;
      sel_reg <= 2'h0;
      dal_reg <= 8'h00;
      strobes_reg <= '0;
      operand_reg <= 16'h0000;
      operand_load_reg <= 1'b0;
      fetch_reg <= 1'b0;
      last_byte_reg <= 8'h00;
    end else if (clk_en) begin
      state_reg <= state_next;
      ccl_prev_reg <= ccl_prev_next;
      dly_reg <= dly_next;
      tmo_reg <= tmo_next;
      clock_stop_ff <= clock_stop_next;
      control_line_active_ff <= ctl_next;
      gated_false_sync <= gfs_next;
      dir_in_reg <= dir_in_next;
      sel_reg <= sel_next;
      dal_reg <= dal_next;
      strobes_reg <= strobes_next;
      operand_reg <= operand_next;
      operand_load_reg <= operand_load_next;
      fetch_reg <= fetch_next_v;
      last_byte_reg <= last_byte_next;
    end
  end

  // Register bus slave
  io_timer_pkg::ahb_req_s req_reg, req_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ctrl_en_next;
  logic ovf_reg, ovf_next;
  logic hready_reg;
  logic addr_ok;
  logic [7:0] addr_lo;

  assign addr_lo = haddr[7:0];
  assign addr_ok = haddr[31:8] == 24'h000000;

  always_comb begin
    req_next.valid = hsel & hready & (htrans == io_timer_pkg::HTRANS_NONSEQ);
    req_next.write = hwrite;
    req_next.addr = addr_lo;
    if (!addr_ok) begin
      req_next.addr = 8'hFF;
    end
    rdata_next = rdata_reg;
    ctrl_en_next = ctrl_en_reg;
    ovf_next = ovf_reg;
    if (req_reg.valid && req_reg.write) begin
      if (req_reg.addr == io_timer_pkg::ADDR_CTRL) begin
        ctrl_en_next = hwdata[io_timer_pkg::CTRL_EN_BIT];
      end
      if (req_reg.addr == io_timer_pkg::ADDR_FLAGS &&
          hwdata[io_timer_pkg::FLAG_OVF_BIT]) begin
        ovf_next = 1'b0;
      end
    end
    // Hardware set wins over software clear
    if (ovf_set) begin
      ovf_next = 1'b1;
    end
    if (req_next.valid && !hwrite) begin
      rdata_next = 32'h00000000;
      case (req_next.addr)
        io_timer_pkg::ADDR_CTRL: begin
          rdata_next[io_timer_pkg::CTRL_EN_BIT] = ctrl_en_reg;
        end
        io_timer_pkg::ADDR_FLAGS: begin
          rdata_next[io_timer_pkg::FLAG_OVF_BIT] = ovf_reg;
        end
        io_timer_pkg::ADDR_STATUS: begin
          rdata_next[2:0] = state_reg;
          rdata_next[3] = clock_stop_ff;
          rdata_next[4] = control_line_active_ff;
          rdata_next[5] = gated_false_sync;
          rdata_next[6] = sync_reg;
          rdata_next[7] = dir_in_reg;
          rdata_next[9:8] = sel_reg;
        end
        io_timer_pkg::ADDR_LAST: begin
          rdata_next[7:0] = last_byte_reg;
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
      rdata_reg <= 32'h00000000;
      ctrl_en_reg <= io_timer_pkg::CTRL_EN_RST;
      ovf_reg <= 1'b0;
      hready_reg <= 1'b0;
    end else if (clk_en) begin
      hready_reg <= 1'b1;
      req_reg <= req_next;
      rdata_reg <= rdata_next;
      ctrl_en_reg <= ctrl_en_next;
      ovf_reg <= ovf_next;
    end
  end

  // Outputs from flops; hresp tied to OKAY
  assign hreadyout = hready_reg;
  assign hresp = io_timer_pkg::HRESP_OKAY;
  assign hrdata = rdata_reg;
  assign sys_clock_run = clock_stop_ff;
  assign operand_bus = operand_reg;
  assign operand_load = operand_load_reg;
  assign fetch_next = fetch_reg;
  assign overflow_flag = ovf_reg;
  assign output_data_lines = dal_reg;
  assign strobes = strobes_reg;

endmodule
`default_nettype wire

// ---- hdl/io_timer_pkg.sv ----
`default_nettype none
package io_timer_pkg;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int CMD_DELAY_NS = 40;
  localparam int CMD_DELAY_CYC = (CMD_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int FS_TIMEOUT_US = 45;
  localparam int FS_TIMEOUT_CYC = FS_TIMEOUT_US * CLK_MHZ;
  localparam int DLY_W = 4;
  localparam int TMO_W = 16;
  // Micro-instruction fields
  localparam int OPC_MSB = 15;
  localparam int DST_MSB = 11;
  localparam int SRC_MSB = 7;
  localparam int SEL_MSB = 1;
  localparam logic [3:0] OP_LOAD = 4'h4;
  localparam logic [3:0] FIELD_IO = 4'hD;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_ADDR_ACK = 2'h2;
  localparam logic [1:0] SEL_CMD_STAT = 2'h3;
  localparam logic [15:0] STATUS_FORCED = 16'h0004;
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LAST = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int FLAG_OVF_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_HALT = 3'b010,
    ST_WAIT = 3'b011,
    ST_RESUME = 3'b100
  } state_e;

  typedef struct packed {
    logic data_available_strobe;
    logic address_strobe;
    logic command_strobe;
    logic data_request_strobe;
    logic acknowledge_strobe;
    logic status_request_strobe;
  } strobes_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_s;
endpackage
`default_nettype wire

// ---- testbench/io_timer_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module io_timer_monitor #(
  parameter int FS_TIMEOUT_CYCLES = io_timer_pkg::FS_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Processor side
  input wire logic [15:0] micro_word,
  input wire logic command_clock,
  input wire logic [7:0] result_bus,
  input wire logic sys_clock_run,
  input wire logic operand_load,
  input wire logic fetch_next,
  // I/O bus
  input wire logic device_sync,
  input wire logic [7:0] output_data_lines,
  input wire io_timer_pkg::strobes_s strobes
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles a strobe has waited without any sync
  logic [15:0] mute_cnt_reg;
  logic [15:0] mute_cnt_next;
  always_comb begin
    mute_cnt_next = ((|strobes) && !device_sync) ? mute_cnt_reg + 16'h1 : 16'h0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mute_cnt_reg <= 16'h0;
    end else begin
      mute_cnt_reg <= mute_cnt_next;
    end
  end
  sequence resume_step;
    fetch_next && !(|strobes);
  endsequence
  sequence io_load;
    micro_word[15:12] == io_timer_pkg::OP_LOAD &&
    (micro_word[11:8] == io_timer_pkg::FIELD_IO ||
     micro_word[7:4] == io_timer_pkg::FIELD_IO) && !command_clock;
  endsequence
  chk_one_strobe: assert property ($onehot0(strobes))
    else $error("more than one strobe active");
  chk_strobe_halted: assert property ($rose(|strobes) |-> !sys_clock_run)
    else $error("strobe rose while clocks run");
  chk_halt_cause: assert property ($fell(sys_clock_run) |-> io_load)
    else $error("clocks halted without an I/O load");
  chk_resume_fetch: assert property ($rose(sys_clock_run) |=> resume_step)
    else $error("no fetch one cycle after resume");
  chk_drop_fetch: assert property ($fell(|strobes) |-> fetch_next)
    else $error("strobe dropped outside completion");
  chk_load_pulse: assert property (operand_load |-> fetch_next ##1 !operand_load)
    else $error("operand load not a completion pulse");
  chk_out_data: assert property ((strobes.data_available_strobe ||
    strobes.address_strobe || strobes.command_strobe) |->
    output_data_lines == result_bus)
    else $error("output lines differ from result byte");
  chk_timeout_bound: assert property (int'(mute_cnt_reg) <= FS_TIMEOUT_CYCLES + 8)
    else $error("false sync did not end the wait");
endmodule
bind io_bus_handshake_timer io_timer_monitor #(
  .FS_TIMEOUT_CYCLES(FS_TIMEOUT_CYCLES)
) u_mon (
  .hclk(hclk), .hresetn(hresetn), .micro_word(micro_word),
  .command_clock(command_clock), .result_bus(result_bus),
  .sys_clock_run(sys_clock_run), .operand_load(operand_load),
  .fetch_next(fetch_next), .device_sync(device_sync),
  .output_data_lines(output_data_lines), .strobes(strobes)
);
`default_nettype wire

// ---- testbench/io_device_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module io_device_model (
  // Clock
  input wire logic hclk,
  // Control from the scenario
  input wire logic respond,
  input wire logic [7:0] reply_byte,
  input wire logic [7:0] reply_delay,
  // I/O bus
  input wire io_timer_pkg::strobes_s strobes,
  output logic device_sync,
  output logic [7:0] input_data_lines
);
  logic [7:0] wait_cnt;
  initial begin
    device_sync = 1'b0;
    input_data_lines = 8'h5A;
    wait_cnt = 8'h00;
  end
  always @(posedge hclk) begin
    if (strobes == 6'h00) begin
      wait_cnt <= 8'h00;
      device_sync <= 1'b0;
      input_data_lines <= ~input_data_lines;
    end else if (respond && wait_cnt == reply_delay) begin
      device_sync <= 1'b1;
      input_data_lines <= reply_byte;
    end else if (!device_sync) begin
      wait_cnt <= wait_cnt + 8'h01;
      input_data_lines <= ~input_data_lines;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, hresp;
  logic hreadyout, command_clock = 1, sys_clock_run, operand_load;
  logic fetch_next, overflow_flag, device_sync, respond = 1, ovf_exp = 0;
  logic [15:0] micro_word = 0, operand_bus;
  logic [7:0] result_bus = 0, input_data_lines, output_data_lines;
  logic [7:0] reply_byte = 0, reply_delay = 2, last_b = 0;
  io_timer_pkg::strobes_s strobes;
  int error_cnt = 0, checked = 0, cyc = 0;
  always #4 hclk = ~hclk;
  io_bus_handshake_timer #(.FS_TIMEOUT_CYCLES(20)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .micro_word(micro_word),
    .command_clock(command_clock), .result_bus(result_bus),
    .sys_clock_run(sys_clock_run), .operand_bus(operand_bus),
    .operand_load(operand_load), .fetch_next(fetch_next),
    .overflow_flag(overflow_flag), .device_sync(device_sync),
    .input_data_lines(input_data_lines),
    .output_data_lines(output_data_lines), .strobes(strobes));
  io_device_model u_dev (.hclk(hclk), .respond(respond),
    .reply_byte(reply_byte), .reply_delay(reply_delay), .strobes(strobes),
    .device_sync(device_sync), .input_data_lines(input_data_lines));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= io_timer_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic kick(input logic [15:0] w);
    micro_word <= w;
    command_clock <= 1'b1;
    @(posedge hclk);
    command_clock <= 1'b0;
  endtask
  task automatic op(input logic inp, input logic [1:0] sel, input logic mute);
    logic [31:0] r;
    logic [5:0] seen_s;
    logic [7:0] seen_d;
    int n;
    r = $urandom;
    respond <= !mute;
    reply_byte <= r[15:8];
    reply_delay <= inp ? 8'h02 : 8'h09;
    result_bus <= r[7:0];
    kick(inp ? {12'h40D, 2'h0, sel} : {12'h4D0, 2'h0, sel});
    seen_s = 0;
    seen_d = 0;
    n = 0;
    while (fetch_next !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
      if (strobes != 6'h00) begin
        seen_s = strobes;
        seen_d = output_data_lines;
      end
    end
    check(seen_s, 6'h01 << (inp ? 3 - sel : 6 - sel));
    if (!inp) check(seen_d, r[7:0]);
    if (inp) check(operand_bus, mute ? (sel == 3 ? 16'h0004 : 16'h0) :
                   {8'h00, r[15:8]});
    if (mute) ovf_exp = 1'b1;
    if (inp && !mute) last_b = r[15:8];
  endtask
  task automatic idle_chk;
    micro_word <= 16'h0000;
    command_clock <= 1'b1;
    repeat (4) @(posedge hclk);
    check(sys_clock_run, 1'b1);
    check(strobes, 6'h00);
    check(overflow_flag, ovf_exp);
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    void'($urandom(68172));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, io_timer_pkg::ADDR_CTRL, 0);
    check(rd, 32'h1);
    ahb(0, io_timer_pkg::ADDR_STATUS, 0);
    check(rd & 32'h1F, 32'h08);
    ahb(0, 8'h10, 0);
    check(rd, 32'h0);
    $display("register reset test done");
    for (int i = 0; i < 6; i++) op(i < 3, 2'(i % 3 + 1), 1'b0);
    idle_chk;
    ahb(0, io_timer_pkg::ADDR_LAST, 0);
    check(rd[7:0], last_b);
    $display("synced transfer test done");
    for (int i = 0; i < 6; i++) op(i >= 3, 2'(i % 3 + 1), 1'b1);
    idle_chk;
    ahb(0, io_timer_pkg::ADDR_FLAGS, 0);
    check(rd[0], 1'b1);
    ahb(1, io_timer_pkg::ADDR_FLAGS, 32'h1);
    ahb(0, io_timer_pkg::ADDR_FLAGS, 0);
    ovf_exp = 1'b0;
    check(rd[0], 1'b0);
    $display("false sync test done");
    kick(16'h4120);
    repeat (12) @(posedge hclk);
    check(sys_clock_run, 1'b1);
    ahb(1, io_timer_pkg::ADDR_CTRL, 32'h0);
    kick(16'h40D1);
    repeat (12) @(posedge hclk);
    check(sys_clock_run, 1'b1);
    ahb(1, io_timer_pkg::ADDR_CTRL, 32'h1);
    idle_chk;
    $display("qualification test done");
    close_out;
  end
endmodule
`default_nettype wire
